// >>> design/ccil_pkg.sv
// Package with register map, field layout, reset values and prescaler constants.
package ccil_pkg;

	// Register offsets within a page; block picks between the overlapping pairs.
	localparam logic [4:0] ADDR_MAIN = 5'h00;
	localparam logic [4:0] ADDR_RT_MODE = 5'h01;
	localparam logic [4:0] ADDR_OUT_MODE = 5'h02;
	localparam logic [4:0] ADDR_TICK_FLAGS = 5'h03;
	localparam logic [4:0] ADDR_PER_EN = 5'h03;
	localparam logic [4:0] ADDR_STEER = 5'h04;
	localparam logic [4:0] ADDR_AP_EN = 5'h04;
	localparam logic [4:0] ADDR_ALARM_BASE = 5'h19;
	localparam int ALARM_BYTES = 6;
	localparam int TICK_FLAGS = 6;

	// Main status bit positions.
	localparam int MS_IRQ = 0;
	localparam int MS_PWR = 1;
	localparam int MS_PER = 2;
	localparam int MS_ALM = 3;
	localparam int MS_TM0 = 4;
	localparam int MS_TM1 = 5;
	localparam int MS_BLOCK = 6;
	localparam int MS_PAGE = 7;

	// Steering bit positions; a one sends the source to the multi-function pin.
	localparam int ST_PWR = 0;
	localparam int ST_PER = 1;
	localparam int ST_ALM = 2;
	localparam int ST_TM0 = 3;
	localparam int ST_TM1 = 4;

	// Enable bit positions beyond the six per-tick and per-byte enables.
	localparam int PE_TM0_EN = 6;
	localparam int PE_TM1_EN = 7;
	localparam int AP_PWR_EN = 6;
	localparam int AP_ALM_EN = 7;

	// Reset values.
	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [7:0] RST_ALARM = 8'h00;

	// Crystal choices and prescaler figures.
	typedef enum logic [1:0] {
		XTAL_32K = 2'b00,
		XTAL_32K768 = 2'b01,
		XTAL_4M9152 = 2'b10,
		XTAL_4M194304 = 2'b11
	} ccil_xtal_t;

	localparam int XTAL_4M9152_HZ = 4915200;
	localparam int XTAL_4M194304_HZ = 4194304;
	localparam int TICK_32K768_HZ = 32768;
	localparam int TICK_32K_HZ = 32000;
	localparam int TICK_100_HZ = 100;
	localparam logic [7:0] PRE_DIV_4M9 = 8'(XTAL_4M9152_HZ / TICK_32K768_HZ - 1);
	localparam logic [7:0] PRE_DIV_4M1 = 8'(XTAL_4M194304_HZ / TICK_32K768_HZ - 1);
	localparam logic [7:0] PRE_DIV_LOW = 8'h00;
	localparam logic [15:0] ACC_STEP = 16'(TICK_100_HZ);
	localparam logic [15:0] ACC_MOD_32K = 16'(TICK_32K_HZ);
	localparam logic [15:0] ACC_MOD_32K768 = 16'(TICK_32K768_HZ);

	// Output mode register layout.
	typedef struct packed {
		logic [2:0] spare;
		logic mfo_is_irq;
		logic mfo_push_pull;
		logic mfo_act_high;
		logic irq_push_pull;
		logic irq_act_high;
	} ccil_pin_cfg_t;

	// One driven output pin.
	typedef struct packed {
		logic level;
		logic oe;
	} ccil_pin_t;

	typedef logic [ALARM_BYTES-1:0][7:0] ccil_time_bytes_t;

endpackage

// >>> design/ccil_irq.sv
// Interrupt logic and digital prescaler of the clock-calendar peripheral.
//
// Contract
// - Divide crystal to 32 kHz, then 100 Hz.
// - Four crystal choices selectable by mode register.
// - A source is enabled only by its bit.
// - Routing bit steers each source to a pin.
// - Output mode sets polarity and drive type.
// - D0 set while either pin is active.
// - D0 counts multi-function pin only when interrupt-configured.
// - D1-D5 set on events; pins need enables.
// - Periodic enables mask D2, never tick flags.
// - Writing one clears D2-D5; zero keeps.
// - Any tick flag access clears all flags.
// - Six tick flags set regardless of enables.
// - Tick flags follow counter rollovers.
// - Periodic enables individual, any combination allowed.
// - One periodic route bit steers all ticks.
// - Write one to D2 cancels periodic interrupt.
// - Pending D2 stays set after enables drop.
// - Alarm fires when all enabled bytes match.
// - Disabled compare byte always matches.
// - Power-fail flag follows signal, ignores clearing.
// - Power-fail steered by route, masked by enable.
// - Power-fail sampling held off during an access.
// - Page and block bits select register set.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ns

module ccil_irq (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [4:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_osc_clk,
	output logic o_tick_32k,
	output logic o_tick_100hz,
	input wire logic [ccil_pkg::TICK_FLAGS-1:0] i_rollover_ticks,
	input wire ccil_pkg::ccil_time_bytes_t i_time_bytes,
	input wire logic [1:0] i_timer_events,
	input wire logic i_power_fail_input_n,
	output logic o_general_irq_pin_o,
	output logic o_general_irq_pin_oe,
	output logic o_multi_function_out_pin_o,
	output logic o_multi_function_out_pin_oe
);

	// Software registers.
	logic [7:0] status_q;
	logic [7:0] status_d;
	logic [7:0] rt_mode_q;
	logic [7:0] out_mode_q;
	logic [7:0] per_en_q;
	logic [7:0] steer_q;
	logic [7:0] ap_en_q;
	logic [ccil_pkg::TICK_FLAGS-1:0] tick_flags_q;
	logic [ccil_pkg::TICK_FLAGS-1:0] tick_flags_d;
	logic [7:0] alarm_q [ccil_pkg::ALARM_BYTES];
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;

	// Address decode.
	wire page0 = ~status_q[ccil_pkg::MS_PAGE];
	wire blk1 = status_q[ccil_pkg::MS_BLOCK];
	wire at_main = (i_addr == ccil_pkg::ADDR_MAIN);
	wire sel_rt_mode = page0 & blk1 & (i_addr == ccil_pkg::ADDR_RT_MODE);
	wire sel_out_mode = page0 & blk1 & (i_addr == ccil_pkg::ADDR_OUT_MODE);
	wire sel_per_en = page0 & blk1 & (i_addr == ccil_pkg::ADDR_PER_EN);
	wire sel_ap_en = page0 & blk1 & (i_addr == ccil_pkg::ADDR_AP_EN);
	wire sel_flags = page0 & ~blk1 & (i_addr == ccil_pkg::ADDR_TICK_FLAGS);
	wire sel_steer = page0 & ~blk1 & (i_addr == ccil_pkg::ADDR_STEER);
	wire [4:0] alarm_off = i_addr - ccil_pkg::ADDR_ALARM_BASE;
	wire sel_alarm = page0 & ~blk1 & (i_addr >= ccil_pkg::ADDR_ALARM_BASE)
		& (alarm_off < 5'(ccil_pkg::ALARM_BYTES));
	wire bus_busy = i_wr | i_rd;

	// Oscillator pin and power-fail pin synchronisers.
	logic osc_s1_q;
	logic osc_s2_q;
	logic osc_s3_q;
	logic pf_s1_q;
	logic pf_s2_q;
	logic pf_q;

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			osc_s1_q <= 1'b0;
			osc_s2_q <= 1'b0;
			osc_s3_q <= 1'b0;
		end else begin
			osc_s1_q <= i_osc_clk;
			osc_s2_q <= osc_s1_q;
			osc_s3_q <= osc_s2_q;
		end
	end

	// The pin idles high, so both stages reset high to avoid a false failure after reset.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			pf_s1_q <= 1'b1;
			pf_s2_q <= 1'b1;
		end else begin
			pf_s1_q <= i_power_fail_input_n;
			pf_s2_q <= pf_s1_q;
		end
	end

	wire osc_edge = osc_s2_q & ~osc_s3_q;

	// Prescaler: first stage to the 32 kHz tick, then a phase accumulator to 100 Hz.
	// The accumulator keeps the 32.768 kHz case exact on average with no fractional divider.
	ccil_pkg::ccil_xtal_t xtal_sel;
	assign xtal_sel = ccil_pkg::ccil_xtal_t'(rt_mode_q[1:0]);
	logic [7:0] pre_cnt_q;
	logic [7:0] pre_div;
	logic [15:0] acc_q;
	logic [15:0] acc_mod;

	always_comb begin
		unique case (xtal_sel)
			ccil_pkg::XTAL_32K: begin
				pre_div = ccil_pkg::PRE_DIV_LOW;
				acc_mod = ccil_pkg::ACC_MOD_32K;
			end
			ccil_pkg::XTAL_32K768: begin
				pre_div = ccil_pkg::PRE_DIV_LOW;
				acc_mod = ccil_pkg::ACC_MOD_32K768;
			end
			ccil_pkg::XTAL_4M9152: begin
				pre_div = ccil_pkg::PRE_DIV_4M9;
				acc_mod = ccil_pkg::ACC_MOD_32K768;
			end
			ccil_pkg::XTAL_4M194304: begin
				pre_div = ccil_pkg::PRE_DIV_4M1;
				acc_mod = ccil_pkg::ACC_MOD_32K768;
			end
		endcase
	end

	wire tick32 = osc_edge & (pre_cnt_q >= pre_div);
	wire [15:0] acc_sum = acc_q + ccil_pkg::ACC_STEP;
	wire tick100 = tick32 & (acc_sum >= acc_mod);

	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			pre_cnt_q <= 8'h00;
		else if (osc_edge)
			pre_cnt_q <= tick32 ? 8'h00 : pre_cnt_q + 8'h01;
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			acc_q <= 16'h0000;
		else if (tick32)
			acc_q <= tick100 ? acc_sum - acc_mod : acc_sum;
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_tick_32k <= 1'b0;
			o_tick_100hz <= 1'b0;
		end else begin
			o_tick_32k <= tick32;
			o_tick_100hz <= tick100;
		end
	end

	logic [ccil_pkg::ALARM_BYTES-1:0] byte_eq;
	genvar gi;
	generate
		for (gi = 0; gi < ccil_pkg::ALARM_BYTES; gi++) begin : g_cmp
			assign byte_eq[gi] = ~ap_en_q[gi] | (i_time_bytes[gi] == alarm_q[gi]);
			always_ff @(posedge i_clk) begin
				if (i_sys_rst)
					alarm_q[gi] <= ccil_pkg::RST_ALARM;
				else if (i_wr & sel_alarm & (alarm_off == 5'(gi)))
					alarm_q[gi] <= i_wdata;
			end
		end
	endgenerate

	// all enabled bytes match; only the onset fires, so a clear sticks.
	logic match_q;
	wire alarm_hit = (&byte_eq) & ~match_q;

	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			match_q <= 1'b1;
		else
			match_q <= &byte_eq;
	end

	// power-fail sampled only when no access.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			pf_q <= 1'b0;
		else if (!bus_busy)
			pf_q <= ~pf_s2_q;
	end

	// any access clears all; a tick in that cycle still sets.
	wire flags_access = bus_busy & sel_flags;
	assign tick_flags_d = (flags_access ? '0 : tick_flags_q) | i_rollover_ticks;

	// enables gate only the summary periodic bit.
	wire per_event = |(i_rollover_ticks & per_en_q[ccil_pkg::TICK_FLAGS-1:0]);
	wire main_wr = i_wr & at_main;
	wire [7:0] w1c = main_wr ? i_wdata : 8'h00;

	// Status next value: set wins over a write-one clear.
	always_comb begin
		status_d = status_q;
		status_d[ccil_pkg::MS_TM1:ccil_pkg::MS_PER] = status_q[ccil_pkg::MS_TM1:ccil_pkg::MS_PER]
			& ~w1c[ccil_pkg::MS_TM1:ccil_pkg::MS_PER];
		if (per_event)
			status_d[ccil_pkg::MS_PER] = 1'b1;
		if (alarm_hit)
			status_d[ccil_pkg::MS_ALM] = 1'b1;
		if (i_timer_events[0])
			status_d[ccil_pkg::MS_TM0] = 1'b1;
		if (i_timer_events[1])
			status_d[ccil_pkg::MS_TM1] = 1'b1;
		status_d[ccil_pkg::MS_PWR] = pf_q;
		if (main_wr) begin
			status_d[ccil_pkg::MS_BLOCK] = i_wdata[ccil_pkg::MS_BLOCK];
			status_d[ccil_pkg::MS_PAGE] = i_wdata[ccil_pkg::MS_PAGE];
		end
		status_d[ccil_pkg::MS_IRQ] = 1'b0;
	end

	// Source pending terms, each gated by its enable except the periodic term.
	// enable bits gate pins.
	// D2 asserts while pending, enables aside.
	wire src_pwr = status_q[ccil_pkg::MS_PWR] & ap_en_q[ccil_pkg::AP_PWR_EN];
	wire src_per = status_q[ccil_pkg::MS_PER];
	wire src_alm = status_q[ccil_pkg::MS_ALM] & ap_en_q[ccil_pkg::AP_ALM_EN];
	wire src_tm0 = status_q[ccil_pkg::MS_TM0] & per_en_q[ccil_pkg::PE_TM0_EN];
	wire src_tm1 = status_q[ccil_pkg::MS_TM1] & per_en_q[ccil_pkg::PE_TM1_EN];
	wire [4:0] srcs = {src_tm1, src_tm0, src_alm, src_per, src_pwr};
	wire [4:0] to_mfo = {steer_q[ccil_pkg::ST_TM1], steer_q[ccil_pkg::ST_TM0],
		steer_q[ccil_pkg::ST_ALM], steer_q[ccil_pkg::ST_PER], steer_q[ccil_pkg::ST_PWR]};

	ccil_pkg::ccil_pin_cfg_t pin_cfg;
	assign pin_cfg = ccil_pkg::ccil_pin_cfg_t'(out_mode_q);
	wire irq_act = |(srcs & ~to_mfo);
	wire mfo_act = (|(srcs & to_mfo)) & pin_cfg.mfo_is_irq;

	// multi-function pin counted only if interrupt-configured.
	wire summary = irq_act | mfo_act;

	// polarity and drive type; open drain only ever pulls low.
	ccil_pkg::ccil_pin_t irq_pin_d;
	ccil_pkg::ccil_pin_t mfo_pin_d;
	ccil_pkg::ccil_pin_t irq_pin_q;
	ccil_pkg::ccil_pin_t mfo_pin_q;
	wire irq_lvl = irq_act ~^ pin_cfg.irq_act_high;
	wire mfo_lvl = mfo_act ~^ pin_cfg.mfo_act_high;
	assign irq_pin_d = '{level: irq_lvl, oe: pin_cfg.irq_push_pull | ~irq_lvl};
	assign mfo_pin_d = '{level: mfo_lvl, oe: pin_cfg.mfo_push_pull | ~mfo_lvl};

	// Read mux; main status reads on every page, other reads outside page 0 registers return zero.
	always_comb begin
		rdata_d = 8'h00;
		if (at_main)
			rdata_d = {status_q[7:1], summary};
		else if (sel_rt_mode)
			rdata_d = rt_mode_q;
		else if (sel_out_mode)
			rdata_d = out_mode_q;
		else if (sel_per_en)
			rdata_d = per_en_q;
		else if (sel_ap_en)
			rdata_d = ap_en_q;
		else if (sel_flags)
			rdata_d = {2'b00, tick_flags_q};
		else if (sel_steer)
			rdata_d = steer_q;
		else if (sel_alarm)
			rdata_d = alarm_q[alarm_off[2:0]];
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			status_q <= ccil_pkg::RST_REG;
		else
			status_q <= status_d;
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			tick_flags_q <= '0;
		else
			tick_flags_q <= tick_flags_d;
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			rdata_q <= 8'h00;
		else
			rdata_q <= i_rd ? rdata_d : 8'h00;
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			rt_mode_q <= ccil_pkg::RST_REG;
		else if (i_wr & sel_rt_mode)
			rt_mode_q <= i_wdata;
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			out_mode_q <= ccil_pkg::RST_REG;
		else if (i_wr & sel_out_mode)
			out_mode_q <= i_wdata;
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			per_en_q <= ccil_pkg::RST_REG;
		else if (i_wr & sel_per_en)
			per_en_q <= i_wdata;
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			ap_en_q <= ccil_pkg::RST_REG;
		else if (i_wr & sel_ap_en)
			ap_en_q <= i_wdata;
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			steer_q <= ccil_pkg::RST_REG;
		else if (i_wr & sel_steer)
			steer_q <= i_wdata;
	end

	// Pins are registered so they never glitch while the sources settle.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			irq_pin_q <= '{level: 1'b0, oe: 1'b0};
		else
			irq_pin_q <= irq_pin_d;
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			mfo_pin_q <= '{level: 1'b0, oe: 1'b0};
		else
			mfo_pin_q <= mfo_pin_d;
	end

	assign o_rdata = rdata_q;
	assign o_general_irq_pin_o = irq_pin_q.level;
	assign o_general_irq_pin_oe = irq_pin_q.oe;
	assign o_multi_function_out_pin_o = mfo_pin_q.level;
	assign o_multi_function_out_pin_oe = mfo_pin_q.oe;

endmodule

// >>> tb/ccil_irq_monitor.sv
// Port-level assertions for the interrupt block.
`timescale 1ns/1ns
module ccil_irq_monitor (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [4:0] i_addr,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic o_tick_32k,
	input wire logic o_tick_100hz,
	input wire logic i_power_fail_input_n,
	input wire logic o_general_irq_pin_o,
	input wire logic o_general_irq_pin_oe,
	input wire logic o_multi_function_out_pin_o,
	input wire logic o_multi_function_out_pin_oe
);
	logic [2:0] pf_cnt_q;
	logic pf_lvl_q;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	// Strobes hold off the power-fail sampling, so only quiet cycles count.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || i_power_fail_input_n != pf_lvl_q) begin
			pf_cnt_q <= 3'h0;
		end else if (!i_wr && !i_rd && pf_cnt_q != 3'h7) begin
			pf_cnt_q <= pf_cnt_q + 3'h1;
		end
		pf_lvl_q <= i_power_fail_input_n;
	end
	rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data not zero when idle");
	unmapped_read_a: assert property (i_rd && i_addr == 5'h10 |=> o_rdata == 8'h00)
		else $error("unmapped read not zero");
	tick_align_a: assert property (o_tick_100hz |-> o_tick_32k)
		else $error("100 Hz tick off the 32 kHz tick");
	tick_pulse_a: assert property (o_tick_32k |=> !o_tick_32k)
		else $error("32 kHz tick too long");
	hz_gap_a: assert property (o_tick_100hz |=> !o_tick_100hz [*8])
		else $error("100 Hz ticks too close");
	irq_drive_a: assert property (!$past(i_sys_rst)
		|-> o_general_irq_pin_o || o_general_irq_pin_oe) else $error("general pin low undriven");
	mfo_drive_a: assert property (!$past(i_sys_rst)
		|-> o_multi_function_out_pin_o || o_multi_function_out_pin_oe)
		else $error("multi-function pin low undriven");
	pf_follow_a: assert property (i_rd && i_addr == 5'h00 && pf_cnt_q == 3'h7
		|=> o_rdata[1] == !$past(pf_lvl_q)) else $error("power-fail status wrong");
	cover property (o_tick_100hz);
	cover property (o_general_irq_pin_oe && o_general_irq_pin_o);
	cover property (o_multi_function_out_pin_oe && o_multi_function_out_pin_o);
endmodule

// >>> tb/ccil_host_model.sv
// Host board view of the two interrupt pins with their pull-up resistors.
`timescale 1ns/1ns
module ccil_host_model (
	input wire logic i_irq_o,
	input wire logic i_irq_oe,
	input wire logic i_mfo_o,
	input wire logic i_mfo_oe,
	output logic o_irq_line,
	output logic o_mfo_line
);
	assign o_irq_line = i_irq_oe ? i_irq_o : 1'b1;
	assign o_mfo_line = i_mfo_oe ? i_mfo_o : 1'b1;
endmodule

// >>> tb/ccil_irq_test.sv
// Self-checking bench of the interrupt block.
`timescale 1ns/1ns
module ccil_irq_test;
	logic i_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic [4:0] i_addr = 5'h00;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_osc_clk = 1'b0;
	logic [5:0] i_rollover_ticks = 6'h00;
	ccil_pkg::ccil_time_bytes_t i_time_bytes = '0;
	logic [1:0] i_timer_events = 2'h0;
	logic i_power_fail_input_n = 1'b1;
	logic [7:0] o_rdata;
	logic o_tick_32k, o_tick_100hz, irq_o, irq_oe, mfo_o, mfo_oe, irq_line, mfo_line;
	logic osc_run = 1'b0;
	logic rd_seen = 1'b0;
	logic [7:0] wm;
	logic [7:0] exp_q[$];
	logic [7:0] msk_q[$];
	logic [31:0] rng = 32'h0000002B;
	int fail_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	ccil_irq i_dut (
		.i_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_osc_clk,
		.o_tick_32k, .o_tick_100hz, .i_rollover_ticks, .i_time_bytes, .i_timer_events,
		.i_power_fail_input_n, .o_general_irq_pin_o(irq_o), .o_general_irq_pin_oe(irq_oe),
		.o_multi_function_out_pin_o(mfo_o), .o_multi_function_out_pin_oe(mfo_oe));
	ccil_host_model i_host (.i_irq_o(irq_o), .i_irq_oe(irq_oe), .i_mfo_o(mfo_o),
		.i_mfo_oe(mfo_oe), .o_irq_line(irq_line), .o_mfo_line(mfo_line));
	always #20 i_clk = ~i_clk;
	always #80 if (osc_run) i_osc_clk = ~i_osc_clk;
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] t;
		t = v ^ (v << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	task automatic end_sim();
		if (fail_count == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		samples_checked++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] e, input logic [7:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
	endtask
	task automatic pulse(input logic [5:0] r, input logic [1:0] t);
		@(posedge i_clk);
		i_rollover_ticks <= r;
		i_timer_events <= t;
		@(posedge i_clk);
		i_rollover_ticks <= 6'h00;
		i_timer_events <= 2'h0;
		repeat (2) @(posedge i_clk);
	endtask
	task automatic pins(input logic [1:0] e);
		chk("pins", 16'(e), 16'({irq_line, mfo_line}));
	endtask
	task automatic measure(output int n);
		@(posedge o_tick_100hz);
		@(posedge i_clk);
		n = 0;
		do begin
			@(posedge i_clk);
			n += int'(o_tick_32k);
		end while (!o_tick_100hz);
	endtask
	task automatic gap(output int n);
		@(posedge o_tick_32k);
		@(posedge i_clk);
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (!o_tick_32k);
	endtask
	always @(posedge i_clk) rd_seen <= i_rd;
	always @(negedge i_clk) begin
		if (rd_seen) begin
			wm = msk_q.pop_front();
			chk("rdata", 16'(exp_q.pop_front() & wm), 16'(o_rdata & wm));
		end
	end
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 32'h00004E20) begin
			fail_count++;
			end_sim();
		end
	end
	initial begin
		int n;
		logic [7:0] a0;
		repeat (6) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		wr(5'h00, 8'hC0);
		wr(5'h02, 8'hFF);
		rd(5'h02, 8'h00, 8'hFF);
		wr(5'h00, 8'h40);
		for (int a = 1; a < 5; a++) rd(5'(a), 8'h00, 8'hFF);
		rd(5'h10, 8'h00, 8'hFF);
		wr(5'h02, 8'h1F);
		wr(5'h03, 8'h41);
		wr(5'h04, 8'hC1);
		wr(5'h00, 8'h00);
		wr(5'h04, 8'h08);
		pulse(6'h08, 2'h0);
		rd(5'h03, 8'h08, 8'h3F);
		rd(5'h03, 8'h00, 8'h3F);
		rd(5'h00, 8'h00, 8'hFF);
		pulse(6'h20, 2'h0);
		wr(5'h03, 8'h00);
		rd(5'h03, 8'h00, 8'h3F);
		pulse(6'h01, 2'h0);
		pins(2'h2);
		wr(5'h00, 8'h40);
		wr(5'h03, 8'h40);
		rd(5'h00, 8'h45, 8'hFF);
		wr(5'h00, 8'h44);
		rd(5'h00, 8'h40, 8'hFF);
		pins(2'h0);
		for (int k = 0; k < 2; k++) begin
			wr(5'h00, 8'h40);
			wr(5'h02, k ? 8'h0F : 8'h1F);
			wr(5'h00, 8'h00);
			pulse(6'h00, 2'h3);
			rd(5'h00, k ? 8'h30 : 8'h31, 8'hFF);
			pins(2'(k == 0));
			wr(5'h00, 8'h10);
			wr(5'h00, 8'h00);
			rd(5'h00, 8'h20, 8'hFF);
			wr(5'h00, 8'h20);
		end
		for (int i = 0; i < 6; i++) begin
			rng = xs(rng);
			wr(5'h19 + 5'(i), rng[7:0]);
			if (i == 0) a0 = rng[7:0];
		end
		rng = xs(rng);
		i_time_bytes <= {rng, rng[15:8], ~a0};
		rd(5'h00, 8'h00, 8'hFF);
		i_time_bytes[0] <= a0;
		repeat (3) @(posedge i_clk);
		rd(5'h00, 8'h09, 8'hFF);
		pins(2'h2);
		wr(5'h00, 8'h08);
		rd(5'h00, 8'h00, 8'hFF);
		i_power_fail_input_n <= 1'b0;
		repeat (8) @(posedge i_clk);
		wr(5'h00, 8'h02);
		rd(5'h00, 8'h03, 8'hFF);
		pins(2'h2);
		wr(5'h00, 8'h40);
		wr(5'h04, 8'h81);
		rd(5'h00, 8'h42, 8'hFF);
		pins(2'h0);
		i_power_fail_input_n <= 1'b1;
		repeat (8) @(posedge i_clk);
		rd(5'h00, 8'h40, 8'hFF);
		osc_run = 1'b1;
		measure(n);
		chk("ticks", 16'h0140, 16'(n));
		wr(5'h01, 8'h01);
		measure(n);
		measure(n);
		chk("ticks", n == 328 ? 16'h0148 : 16'h0147, 16'(n));
		wr(5'h01, 8'h02);
		gap(n);
		gap(n);
		chk("gap", 16'h0258, 16'(n));
		wr(5'h01, 8'h03);
		gap(n);
		gap(n);
		chk("gap", 16'h0200, 16'(n));
		repeat (3) @(posedge i_clk);
		end_sim();
	end
endmodule
bind ccil_irq ccil_irq_monitor i_mon (.i_clk, .i_sys_rst, .i_addr, .i_wr, .i_rd, .o_rdata,
	.o_tick_32k, .o_tick_100hz, .i_power_fail_input_n, .o_general_irq_pin_o,
	.o_general_irq_pin_oe, .o_multi_function_out_pin_o, .o_multi_function_out_pin_oe);
